// *** design/safe_stop_drive.sv ***
// What this block does
// - stop selection starts quick-stop braking at once
// - ramp supervision waits for ramp-delay timer
// - speed must stay under permitted braking ramp
// - ramp supervision ends below speed limit
// - torque off on stop delay or shutdown speed
// - after torque off, pulses stay inhibited
// - deselection gives ready; restart needs on edge
// - stop and torque-removed status flags
// - hold selected only by telegram bit
// - hold accel variant limits speed rise above the lowest speed seen
// - accel threshold tracks falling speed plus tolerance
// - accel supervision off below shared limit
// - hold ramp variant starts ramp-delay timer
// - hold delay expiry enters standstill supervision
// - standstill keeps closed loop, checks position
// - standstill violation runs stop then torque off
// - hold and standstill status flags
// - hold deselection allows immediate motion
// - selection and supervision in two channels
// - controller must not coast-stop on quick stop
// - external motion control prefers external braking
// - selection, supervision, timers and state evaluated once per 4 ms cycle; on edge caught every clock
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module safe_stop_drive #(
  parameter int unsigned MON_CYCLE_CLKS = safe_stop_pkg::MON_CYCLE_CLKS
) (
  input wire logic pclk,                                          // system clock
  input wire logic presetn,                                       // async reset, low
  safe_stop_if.drive_end link,                                    // safety telegram
  input wire logic failsafe_digital_input,                        // stop select pin
  input wire logic [safe_stop_pkg::SPEED_W-1:0] speed_actual,     // speed magnitude
  input wire logic [safe_stop_pkg::POS_W-1:0] position_actual,    // motor position
  output logic quick_stop_ramp,                                   // brake on ramp
  output logic pulse_inhibit,                                     // pulses blocked
  output logic closed_loop_hold,                                  // hold in control
  output logic ready_to_switch_on                                 // ready state
);
  localparam int unsigned NCH = 2;

  // saturating speed plus tolerance, used by both supervisions
  function automatic logic [safe_stop_pkg::SPEED_W-1:0] add_tol(input logic [safe_stop_pkg::SPEED_W-1:0] s);
    logic [safe_stop_pkg::SPEED_W:0] sum;
    sum = {1'b0, s} + {1'b0, safe_stop_pkg::SPEED_TOLERANCE};
    add_tol = sum[safe_stop_pkg::SPEED_W] ? safe_stop_pkg::SPEED_MAX : sum[safe_stop_pkg::SPEED_W-1:0];
  endfunction

  safe_stop_pkg::drive_state_e state_ff, nxt_state;
  logic [safe_stop_pkg::TICK_W-1:0] tick_cnt_ff;
  logic tick_ff;
  logic [safe_stop_pkg::TIMER_W-1:0] t_ramp_ff, t_main_ff;
  logic [safe_stop_pkg::POS_W-1:0] pos_hold_ff;
  logic on_off_prev_ff, on_req_ff, reaction_ff, fault_ff;
  logic [NCH-1:0] ch_stop_ff, ch_hold_ff, ch_viol;
  logic [safe_stop_pkg::SPEED_W-1:0] ch_lim_ff [NCH];
  logic [safe_stop_pkg::SPEED_W-1:0] ch_thr_ff [NCH];
  logic quick_stop_ff, inhibit_ff, hold_loop_ff, ready_ff;
  logic stop_flag_ff, torque_flag_ff, hold_flag_ff, sos_flag_ff, fault_flag_ff;

  // monitoring cycle strobe; channels, timers and state move only on it
  wire tick_wrap = (tick_cnt_ff == safe_stop_pkg::TICK_W'(MON_CYCLE_CLKS - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= tick_wrap ? '0 : tick_cnt_ff + 1'b1;
      tick_ff <= tick_wrap;
    end
  end

  // selection and state decode
  wire stop_req = link.stop_select | failsafe_digital_input;
  wire hold_req = link.hold_select;
  wire stop_sel = |ch_stop_ff;  // either channel may select, safe side
  wire hold_sel = |ch_hold_ff;
  wire ch_mismatch = (ch_stop_ff[0] != ch_stop_ff[1]) | (ch_hold_ff[0] != ch_hold_ff[1]);
  wire in_stop = (state_ff == safe_stop_pkg::ST_STOP_BRAKE);
  wire in_hold = (state_ff == safe_stop_pkg::ST_HOLD_BRAKE);
  wire braking = in_stop | in_hold;
  wire above_limit = (speed_actual >= safe_stop_pkg::SUPERVISION_SPEED_LIMIT);
  wire ramp_delay_done = (t_ramp_ff >= safe_stop_pkg::RAMP_MONITOR_DELAY_CYC);
  wire ramp_sup_on = (in_stop | (in_hold & link.hold_ramp_variant)) & ramp_delay_done & above_limit;
  wire accel_sup_on = in_hold & ~link.hold_ramp_variant & above_limit;
  wire sup_viol = |ch_viol;
  wire stop_delay_done = (t_main_ff >= safe_stop_pkg::STOP_DELAY_CYC);
  wire hold_delay_done = (t_main_ff >= safe_stop_pkg::HOLD_DELAY_CYC);
  wire below_shutdown = (speed_actual < safe_stop_pkg::SHUTDOWN_SPEED);
  wire [safe_stop_pkg::POS_W:0] pos_diff = {1'b0, position_actual} - {1'b0, pos_hold_ff};
  wire [safe_stop_pkg::POS_W:0] pos_abs = pos_diff[safe_stop_pkg::POS_W] ? (~pos_diff + 1'b1) : pos_diff;
  wire sos_viol = (state_ff == safe_stop_pkg::ST_STANDSTILL) & (pos_abs > safe_stop_pkg::STANDSTILL_TOLERANCE);
  wire stop_release = ~stop_sel & ~(reaction_ff & hold_sel);
  wire on_edge = link.on_off_command & ~on_off_prev_ff;

  // two redundant channels for selection and supervision; the quick-stop ramp itself is single
  for (genvar i = 0; i < NCH; i++) begin : g_chan
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ch_stop_ff[i] <= 1'b0;
        ch_hold_ff[i] <= 1'b0;
        ch_lim_ff[i] <= '0;
        ch_thr_ff[i] <= '0;
      end else if (tick_ff) begin
        ch_stop_ff[i] <= stop_req;
        ch_hold_ff[i] <= hold_req;
        // permitted ramp starts at speed plus tolerance at selection, then falls one step per cycle
        if (!braking) begin
          ch_lim_ff[i] <= add_tol(speed_actual);
        end else begin
          ch_lim_ff[i] <= (ch_lim_ff[i] > safe_stop_pkg::RAMP_STEP) ? ch_lim_ff[i] - safe_stop_pkg::RAMP_STEP : '0;
        end
        // during hold the accel threshold only moves down with speed, so re-acceleration trips it
        if (!in_hold || add_tol(speed_actual) < ch_thr_ff[i]) begin
          ch_thr_ff[i] <= add_tol(speed_actual);
        end
      end
    end
    assign ch_viol[i] = (ramp_sup_on & (speed_actual > ch_lim_ff[i])) |
                        (accel_sup_on & (speed_actual > ch_thr_ff[i]));
  end

  // state transitions, taken only on the monitoring strobe
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      safe_stop_pkg::ST_READY: begin
        if (stop_sel) begin
          nxt_state = safe_stop_pkg::ST_STOP_BRAKE;
        end else if (on_req_ff) begin
          nxt_state = safe_stop_pkg::ST_RUN;
        end
      end
      safe_stop_pkg::ST_RUN: begin
        if (stop_sel) begin
          nxt_state = safe_stop_pkg::ST_STOP_BRAKE;
        end else if (hold_sel) begin
          nxt_state = safe_stop_pkg::ST_HOLD_BRAKE;
        end else if (link.coast_stop_command) begin
          nxt_state = safe_stop_pkg::ST_READY;
        end
      end
      safe_stop_pkg::ST_STOP_BRAKE: begin
        if (stop_release) begin
          nxt_state = safe_stop_pkg::ST_READY;
        end else if (sup_viol || stop_delay_done || below_shutdown) begin
          nxt_state = safe_stop_pkg::ST_TORQUE_OFF;
        end
      end
      safe_stop_pkg::ST_TORQUE_OFF: begin
        if (stop_release) begin
          nxt_state = safe_stop_pkg::ST_READY;
        end
      end
      safe_stop_pkg::ST_HOLD_BRAKE: begin
        if (stop_sel) begin
          nxt_state = safe_stop_pkg::ST_STOP_BRAKE;
        end else if (!hold_sel) begin
          nxt_state = safe_stop_pkg::ST_RUN;
        end else if (sup_viol) begin
          nxt_state = safe_stop_pkg::ST_TORQUE_OFF;
        end else if (hold_delay_done) begin
          nxt_state = safe_stop_pkg::ST_STANDSTILL;
        end
      end
      safe_stop_pkg::ST_STANDSTILL: begin
        if (stop_sel || sos_viol) begin
          nxt_state = safe_stop_pkg::ST_STOP_BRAKE;
        end else if (!hold_sel) begin
          nxt_state = safe_stop_pkg::ST_RUN;
        end
      end
      default: nxt_state = safe_stop_pkg::ST_TORQUE_OFF;
    endcase
  end

  // state, timers and latched conditions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= safe_stop_pkg::ST_READY;
      t_ramp_ff <= '0;
      t_main_ff <= '0;
      pos_hold_ff <= '0;
      reaction_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else if (tick_ff) begin
      state_ff <= nxt_state;
      // timers restart on every state change, so each selection starts them afresh
      t_ramp_ff <= (nxt_state != state_ff) ? '0 : (t_ramp_ff == safe_stop_pkg::TIMER_MAX) ? t_ramp_ff : t_ramp_ff + 1'b1;
      t_main_ff <= (nxt_state != state_ff) ? '0 : (t_main_ff == safe_stop_pkg::TIMER_MAX) ? t_main_ff : t_main_ff + 1'b1;
      if (nxt_state == safe_stop_pkg::ST_STANDSTILL && state_ff != safe_stop_pkg::ST_STANDSTILL) begin
        pos_hold_ff <= position_actual;
      end
      // set wins over clear for both latches
      reaction_ff <= sos_viol | (reaction_ff & (nxt_state != safe_stop_pkg::ST_READY));
      fault_ff <= sup_viol | ch_mismatch |
                  (fault_ff & (nxt_state != safe_stop_pkg::ST_READY) & (nxt_state != safe_stop_pkg::ST_RUN));
    end
  end

  // on command edge is caught between strobes so a short pulse is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_off_prev_ff <= 1'b0;
      on_req_ff <= 1'b0;
    end else begin
      on_off_prev_ff <= link.on_off_command;
      on_req_ff <= (on_edge & (state_ff == safe_stop_pkg::ST_READY)) |
                   (on_req_ff & (state_ff == safe_stop_pkg::ST_READY));
    end
  end

  // registered outputs and telegram status, decoded from the current state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quick_stop_ff <= 1'b0;
      inhibit_ff <= 1'b1;
      hold_loop_ff <= 1'b0;
      ready_ff <= 1'b1;
      stop_flag_ff <= 1'b0;
      torque_flag_ff <= 1'b0;
      hold_flag_ff <= 1'b0;
      sos_flag_ff <= 1'b0;
      fault_flag_ff <= 1'b0;
    end else begin
      quick_stop_ff <= (state_ff == safe_stop_pkg::ST_STOP_BRAKE) | in_hold;
      inhibit_ff <= (state_ff == safe_stop_pkg::ST_TORQUE_OFF) | (state_ff == safe_stop_pkg::ST_READY);
      hold_loop_ff <= (state_ff == safe_stop_pkg::ST_STANDSTILL);
      ready_ff <= (state_ff == safe_stop_pkg::ST_READY);
      stop_flag_ff <= in_stop | (state_ff == safe_stop_pkg::ST_TORQUE_OFF);
      torque_flag_ff <= (state_ff == safe_stop_pkg::ST_TORQUE_OFF);
      // hold status covers the whole hold path, so standstill status never shows without it
      hold_flag_ff <= in_hold | (state_ff == safe_stop_pkg::ST_STANDSTILL) |
                      (hold_sel & (state_ff != safe_stop_pkg::ST_READY));
      sos_flag_ff <= (state_ff == safe_stop_pkg::ST_STANDSTILL);
      // fault moves on the same clock as the state-derived flags, never ahead of them
      fault_flag_ff <= fault_ff;
    end
  end

  assign quick_stop_ramp = quick_stop_ff;
  assign pulse_inhibit = inhibit_ff;
  assign closed_loop_hold = hold_loop_ff;
  assign ready_to_switch_on = ready_ff;
  assign link.stop_active_flag = stop_flag_ff;
  assign link.torque_removed_flag = torque_flag_ff;
  assign link.stop_hold_active_flag = hold_flag_ff;
  assign link.standstill_active_flag = sos_flag_ff;
  assign link.fault_flag = fault_flag_ff;
  assign link.ready_flag = ready_ff;
endmodule
`default_nettype wire

// *** inc/safe_stop_pkg.sv ***
package safe_stop_pkg;
  // monitoring cycle and clock
  localparam int unsigned CLK_FREQ_KHZ = 250000;
  localparam int unsigned MON_CYCLE_MS = 4;
  localparam int unsigned MON_CYCLE_CLKS = MON_CYCLE_MS * CLK_FREQ_KHZ;
  localparam int unsigned TICK_W = 20;
  localparam int unsigned TIMER_W = 10;
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned POS_W = 16;

  // configured times in ms, timers count monitoring cycles (least times, rounded up)
  localparam int unsigned RAMP_MONITOR_DELAY_TIME_MS = 100;
  localparam int unsigned STOP_DELAY_TIME_MS = 2000;
  localparam int unsigned HOLD_DELAY_TIME_MS = 2000;
  localparam int unsigned RAMP_MONITORING_TIME_MS = 1000;
  localparam logic [TIMER_W-1:0] RAMP_MONITOR_DELAY_CYC =
    TIMER_W'((RAMP_MONITOR_DELAY_TIME_MS + MON_CYCLE_MS - 1) / MON_CYCLE_MS);
  localparam logic [TIMER_W-1:0] STOP_DELAY_CYC = TIMER_W'((STOP_DELAY_TIME_MS + MON_CYCLE_MS - 1) / MON_CYCLE_MS);
  localparam logic [TIMER_W-1:0] HOLD_DELAY_CYC = TIMER_W'((HOLD_DELAY_TIME_MS + MON_CYCLE_MS - 1) / MON_CYCLE_MS);
  localparam logic [TIMER_W-1:0] TIMER_MAX = 10'h3FF;

  // configured speeds and position window
  localparam logic [SPEED_W-1:0] RAMP_REFERENCE_SPEED = 16'h0BB8;
  localparam logic [SPEED_W-1:0] SUPERVISION_SPEED_LIMIT = 16'h0032;
  localparam logic [SPEED_W-1:0] SHUTDOWN_SPEED = 16'h0014;
  localparam logic [SPEED_W-1:0] SPEED_TOLERANCE = 16'h0064;
  localparam logic [POS_W:0] STANDSTILL_TOLERANCE = 17'h00010;
  localparam logic [SPEED_W-1:0] SPEED_MAX = 16'hFFFF;
  // permitted speed drop per monitoring cycle along the braking ramp
  localparam logic [SPEED_W-1:0] RAMP_STEP =
    SPEED_W'(int'(RAMP_REFERENCE_SPEED) * MON_CYCLE_MS / RAMP_MONITORING_TIME_MS);

  // controller register map on apb
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam int unsigned CTRL_STOP_BIT = 0;
  localparam int unsigned CTRL_HOLD_BIT = 1;
  localparam int unsigned CTRL_VARIANT_BIT = 2;
  localparam int unsigned CTRL_ON_OFF_BIT = 3;
  localparam int unsigned CTRL_COAST_BIT = 4;
  localparam int unsigned CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam int unsigned STATUS_W = 6;

  typedef enum logic [2:0] {
    ST_READY,
    ST_RUN,
    ST_STOP_BRAKE,
    ST_TORQUE_OFF,
    ST_HOLD_BRAKE,
    ST_STANDSTILL
  } drive_state_e;
endpackage

// *** inc/safe_stop_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// safety telegram between controller and drive
interface safe_stop_if;
  logic stop_select;
  logic hold_select;
  logic hold_ramp_variant;
  logic on_off_command;
  logic coast_stop_command;
  logic stop_active_flag;
  logic torque_removed_flag;
  logic stop_hold_active_flag;
  logic standstill_active_flag;
  logic fault_flag;
  logic ready_flag;

  modport drive_end (
    input stop_select, hold_select, hold_ramp_variant, on_off_command, coast_stop_command,
    output stop_active_flag, torque_removed_flag, stop_hold_active_flag, standstill_active_flag,
    fault_flag, ready_flag
  );
  modport ctrl_end (
    output stop_select, hold_select, hold_ramp_variant, on_off_command, coast_stop_command,
    input stop_active_flag, torque_removed_flag, stop_hold_active_flag, standstill_active_flag,
    fault_flag, ready_flag
  );
endinterface
`default_nettype wire

// *** design/safe_stop_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module safe_stop_ctrl (
  input wire logic pclk,                                   // system clock
  input wire logic presetn,                                // async reset, low
  input wire logic [safe_stop_pkg::ADDR_W-1:0] paddr,      // apb address
  input wire logic psel,                                   // apb select
  input wire logic penable,                                // apb enable
  input wire logic pwrite,                                 // apb direction
  input wire logic [31:0] pwdata,                          // apb write data
  output logic [31:0] prdata,                              // apb read data
  output logic pready,                                     // apb ready
  output logic pslverr,                                    // apb error
  safe_stop_if.ctrl_end link                               // safety telegram
);
  logic [safe_stop_pkg::CTRL_W-1:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, coast_ff;

  // address decode; pready rises at the start of every access phase, no wait states
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_ff;
  wire hit_ctrl = (paddr == safe_stop_pkg::CTRL_OFFSET);
  wire hit_status = (paddr == safe_stop_pkg::STATUS_OFFSET);
  wire unmapped = ~hit_ctrl & ~hit_status;
  wire [safe_stop_pkg::STATUS_W-1:0] status = {link.fault_flag, link.ready_flag, link.standstill_active_flag,
                                               link.stop_hold_active_flag, link.torque_removed_flag,
                                               link.stop_active_flag};
  wire [31:0] rd_mux = hit_ctrl ? {{(32 - safe_stop_pkg::CTRL_W){1'b0}}, ctrl_ff} :
                       hit_status ? {{(32 - safe_stop_pkg::STATUS_W){1'b0}}, status} : 32'h00000000;

  // bus slave: read data and error prepared at setup, write lands at the accepting edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= safe_stop_pkg::CTRL_RESET;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & unmapped;
      if (setup) begin
        prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
      end
      if (access && pwrite && hit_ctrl) begin
        ctrl_ff <= pwdata[safe_stop_pkg::CTRL_W-1:0];
      end
    end
  end

  // a coast stop is held back while the drive brakes by itself, so the ramp is never cut short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coast_ff <= 1'b0;
    end else begin
      coast_ff <= ctrl_ff[safe_stop_pkg::CTRL_COAST_BIT] &
                  ~(link.stop_active_flag | link.stop_hold_active_flag);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign link.stop_select = ctrl_ff[safe_stop_pkg::CTRL_STOP_BIT];
  assign link.hold_select = ctrl_ff[safe_stop_pkg::CTRL_HOLD_BIT];
  assign link.hold_ramp_variant = ctrl_ff[safe_stop_pkg::CTRL_VARIANT_BIT]; // setpoint-led axes brake externally
  assign link.on_off_command = ctrl_ff[safe_stop_pkg::CTRL_ON_OFF_BIT];
  assign link.coast_stop_command = coast_ff;
endmodule
`default_nettype wire

// *** sim/safe_stop_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module safe_stop_assertions (
  input wire logic pclk,                   // clock
  input wire logic presetn,                // async reset, low
  input wire logic stop_select,            // stop request
  input wire logic hold_select,            // hold request
  input wire logic hold_ramp_variant,      // hold variant
  input wire logic on_off_command,         // restart command
  input wire logic coast_stop_command,     // coast request
  input wire logic stop_active_flag,       // stop status
  input wire logic torque_removed_flag,    // torque off status
  input wire logic stop_hold_active_flag,  // hold status
  input wire logic standstill_active_flag, // standstill status
  input wire logic fault_flag,             // latched fault
  input wire logic ready_flag              // ready status
);
  logic [4:0] sel_cnt_ff;
  logic [4:0] nxt_sel_cnt;

  // consecutive cycles of stop selection, saturating so it never wraps back to 20
  assign nxt_sel_cnt = !stop_select ? 5'h00 : ((sel_cnt_ff == 5'h1F) ? sel_cnt_ff : sel_cnt_ff + 5'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_cnt_ff <= 5'h00;
    end else begin
      sel_cnt_ff <= nxt_sel_cnt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // 20 clocks cover one strobe wait, one state step and the flag register
  a_stop_reacts: assert property (sel_cnt_ff == 5'h14 |-> (stop_active_flag || torque_removed_flag))
    else $error("stop selected but no stop status");
  a_torque_in_stop: assert property (torque_removed_flag |-> stop_active_flag)
    else $error("torque removed outside stop");
  a_ready_clean: assert property (ready_flag |-> !stop_active_flag && !torque_removed_flag && !stop_hold_active_flag)
    else $error("ready with stop states set");
  a_standstill_in_hold: assert property (standstill_active_flag |-> stop_hold_active_flag)
    else $error("standstill without hold");
  a_hold_release: assert property ($fell(hold_select) && !stop_select |-> ##[1:20] !stop_hold_active_flag)
    else $error("hold not released after deselection");
  a_hold_on_strobe: assert property ($changed(stop_hold_active_flag) |=> $stable(stop_hold_active_flag) [*7])
    else $error("hold status changed between strobes");
  a_fault_torque: assert property ($rose(fault_flag) |-> ##[0:2] torque_removed_flag)
    else $error("fault without torque removal");
  a_fault_latched: assert property ($fell(fault_flag) |-> !torque_removed_flag && !stop_active_flag)
    else $error("fault cleared while stopped");
  a_coast_held: assert property ($past(stop_active_flag) || $past(stop_hold_active_flag) |-> !coast_stop_command)
    else $error("coast stop passed while drive brakes");
endmodule
`default_nettype wire

// *** sim/safe_stop_ramp_monitor_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module safe_stop_ramp_monitor_bench;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fdi;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] speed, pos;
  logic qsr, pinh, clh, rdy;
  int err_count, check_count;
  row_s rows [6];

  safe_stop_if link ();
  safe_stop_ctrl i_safe_stop_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  // short monitor cycle keeps the 500-cycle delays affordable
  safe_stop_drive #(.MON_CYCLE_CLKS(8)) i_safe_stop_drive (.pclk(pclk), .presetn(presetn), .link(link),
    .failsafe_digital_input(fdi), .speed_actual(speed), .position_actual(pos), .quick_stop_ramp(qsr),
    .pulse_inhibit(pinh), .closed_loop_hold(clh), .ready_to_switch_on(rdy));
  safe_stop_assertions i_safe_stop_assertions (.pclk(pclk), .presetn(presetn), .stop_select(link.stop_select),
    .hold_select(link.hold_select), .hold_ramp_variant(link.hold_ramp_variant), .on_off_command(link.on_off_command),
    .coast_stop_command(link.coast_stop_command), .stop_active_flag(link.stop_active_flag),
    .torque_removed_flag(link.torque_removed_flag), .stop_hold_active_flag(link.stop_hold_active_flag),
    .standstill_active_flag(link.standstill_active_flag), .fault_flag(link.fault_flag), .ready_flag(link.ready_flag));

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, safe_stop_pkg::CTRL_OFFSET, d, r, e);
  endtask

  task rd_status(input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'h0, safe_stop_pkg::STATUS_OFFSET, 32'h0, r, e);
    chk(r, exp);
  endtask

  // poll a status bit with a bounded number of reads
  task wait_bit(input int b, input logic v, input int lim);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    apb(1'h0, safe_stop_pkg::STATUS_OFFSET, 32'h0, r, e);
    while (r[b] !== v && n < lim) begin
      apb(1'h0, safe_stop_pkg::STATUS_OFFSET, 32'h0, r, e);
      n++;
    end
    chk(32'(r[b]), 32'(v));
  endtask

  task summarize;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs about 9000 clocks
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    summarize();
  end

  initial begin
    logic [31:0] r;
    logic e;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fdi = 1'h0;
    speed = 16'h0000;
    pos = 16'h0000;
    err_count = 0;
    check_count = 0;
    // upper ctrl bits read back 0, unmapped places answer with an error
    rows[0] = '{1'h1, 8'h00, 32'hFFFF_FFE0, 32'h0, 1'h0};
    rows[1] = '{1'h0, 8'h00, 32'h0, 32'h0, 1'h0};
    rows[2] = '{1'h0, 8'h04, 32'h0, 32'h10, 1'h0};
    rows[3] = '{1'h1, 8'h08, 32'h1, 32'h0, 1'h1};
    rows[4] = '{1'h0, 8'h08, 32'h0, 32'h0, 1'h1};
    rows[5] = '{1'h0, 8'hFC, 32'h0, 32'h0, 1'h1};
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk(32'({pinh, rdy, qsr, clh}), 32'h0C);
    for (int i = 0; i < 6; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d, r, e);
      if (!rows[i].w) begin
        chk(r, rows[i].exp);
      end
      chk(32'(e), 32'(rows[i].err));
    end
    $display("register table done");
    // pin stop at low speed: torque off at once, then restart needs a new edge
    wr(32'h08);
    wait_bit(4, 1'h0, 20);
    speed <= 16'h000A;
    fdi <= 1'h1;
    wait_bit(1, 1'h1, 40);
    rd_status(32'h03);
    chk(32'(pinh), 32'h1);
    wr(32'h18);
    repeat (2) @(posedge pclk);
    chk(32'(link.coast_stop_command), 32'h0);
    fdi <= 1'h0;
    wait_bit(4, 1'h1, 40);
    repeat (40) @(posedge pclk);
    rd_status(32'h10);
    wr(32'h00);
    wr(32'h08);
    wait_bit(4, 1'h0, 20);
    wr(32'h18);
    wait_bit(4, 1'h1, 40);
    wr(32'h00);
    wr(32'h08);
    wait_bit(4, 1'h0, 20);
    $display("pin stop done");
    // telegram stop with speed held: braking first, ramp violation after the delay
    speed <= 16'h03E8;
    wr(32'h09);
    repeat (100) @(posedge pclk);
    chk(32'({qsr, pinh}), 32'h2);
    wait_bit(5, 1'h1, 150);
    rd_status(32'h23);
    speed <= 16'h0000;
    wr(32'h00);
    wait_bit(4, 1'h1, 40);
    rd_status(32'h10);
    wr(32'h08);
    wait_bit(4, 1'h0, 20);
    $display("ramp violation done");
    // accel-monitored hold with a speed rise: the threshold only falls, so the rise trips it
    speed <= 16'h03E8;
    wr(32'h0A);
    wait_bit(2, 1'h1, 40);
    repeat (16) @(posedge pclk);
    speed <= 16'h04B0;
    wait_bit(5, 1'h1, 40);
    rd_status(32'h27);
    speed <= 16'h0000;
    wr(32'h00);
    wait_bit(4, 1'h1, 40);
    wr(32'h08);
    wait_bit(4, 1'h0, 20);
    $display("accel violation done");
    // accel-monitored hold: standstill after the hold delay, release keeps running
    wr(32'h0A);
    wait_bit(2, 1'h1, 40);
    chk(32'(link.standstill_active_flag), 32'h0);
    wait_bit(3, 1'h1, 2000);
    rd_status(32'h0C);
    chk(32'({clh, pinh}), 32'h2);
    wr(32'h08);
    wait_bit(2, 1'h0, 40);
    rd_status(32'h00);
    chk(32'(pinh), 32'h0);
    $display("hold done");
    // ramp-monitored hold with the position pushed out of the window
    wr(32'h0E);
    wait_bit(3, 1'h1, 2000);
    pos <= 16'h0020;
    wait_bit(1, 1'h1, 60);
    apb(1'h0, safe_stop_pkg::STATUS_OFFSET, 32'h0, r, e);
    chk(r & 32'h03, 32'h03);
    pos <= 16'h0000;
    wr(32'h00);
    wait_bit(4, 1'h1, 40);
    $display("standstill violation done");
    summarize();
  end
endmodule
`default_nettype wire
